// ### include/vsm_pkg.sv
// constants and carrier types for the vid slew mode sequencer
// Notes on behaviour
// - dual-phase skip levels: phases alternate half a period apart, both high-sides on only during overlap.
// - output low at min off-time expiry after a high-side turns off: fire both next.
// - overlap lasts until output is above regulation at min off-time expiry.
// - after overlap, alternation resumes with the phase opposite the last single pulse.
// - on enable, reference powers first; target and switching wait for its lockout pass.
// - startup ramps from zero in single steps to vid or suspend target.
// - power-up ramp advances at one quarter of the slew tick rate.
// - power-good stays low until 3ms after power-up ramp reaches target.
// - enable low drops power-good at once, ramps down at four times tick rate.
// - at zero code after ramp-down: low-sides high, high-sides low, reference off.
// - undervoltage, overvoltage or thermal fault starts shutdown and sets the fault latch.
// - while active, a vid change starts a slewed transition to the new code.
// - enable low, once the ramp down reaches zero, forces low-sides high, high-sides low, controller off.
// - normal: suspend ground, skip high, offset off regulates vid with no offset.
// - skip at ground or reference enters pulse skipping and blanks upper power-good check.
// - suspend ground with offset in a valid band adds offset to the vid target.
// - suspend at reference or high selects suspend code, no offset, overriding all.
// - power-good blanked during transitions and 24 slew ticks after final code.
// - undervoltage below 70% of nominal starts shutdown and sets the fault latch.
// - no-fault test mode disables protections and overlap and clears the fault latch.
`default_nettype none
package vsm_pkg;
   // ****************************************************************
   // widths and timing
   // ****************************************************************
   localparam int CODE_W = 6;
   localparam int CLK_MHZ = 200;
   localparam int PGOOD_DELAY_US = 3000;
   localparam int PGOOD_DELAY_CYC = PGOOD_DELAY_US * CLK_MHZ;
   localparam int BLANK_TICKS = 24;
   localparam int QUARTER_DIV = 4;
   localparam int FAST_MULT = 4;
   localparam logic [5:0] CODE_ZERO = 6'h00;
   localparam logic [1:0] SEL_GND = 2'h0;
   localparam logic [1:0] SEL_REF = 2'h1;
   localparam logic [1:0] SEL_HIGH = 2'h2;

   // ****************************************************************
   // carrier types
   // ****************************************************************
   typedef enum logic [2:0] {ST_OFF, ST_REFUP, ST_RAMPUP, ST_RUN, ST_RAMPDN, ST_HALT}
      vsm_state_t;
   typedef struct packed {
      logic [1:0] susSel;     // tri-level suspend select
      logic [1:0] skipSel;    // tri-level pulse-skip select
      logic offsetValid;      // offset level in a defined band
      logic [5:0] vidCode;
      logic [5:0] suspendCode;
   } vsm_mode_in_t;
   typedef struct packed {
      logic highSideMain;
      logic highSideSec;
      logic lowSideMain;
      logic lowSideSec;
   } vsm_gates_t;
   typedef struct packed {
      logic onRequest;      // one-shot ready to fire next on-time
      logic minOffExpired;  // pulse: minimum off-time expired
      logic aboveReg;       // output above regulation
   } vsm_pwm_in_t;
endpackage
`default_nettype wire

// ### verilog/vsm_phase_ctl.sv
// alternating and overlapped high-side firing decision
`default_nettype none
module vsm_phase_ctl
   import vsm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstSync_n,
   input wire logic run,
   input wire logic dualPhase,
   input wire logic overlapAllow,
   input wire vsm_pkg::vsm_pwm_in_t pwmIn,
   output logic fireMain,
   output logic fireSec,
   output logic overlapActive
);
   typedef struct packed {
      logic overlap;
      logic lastSec;   // phase of last single pulse
      logic mainPulse;
      logic secPulse;
   } vsm_phase_state_t;
   vsm_phase_state_t st, next_st;

   // decide who fires on each on-time request
   always_comb
   begin
      next_st = st;
      next_st.mainPulse = 1'b0;
      next_st.secPulse = 1'b0;
      if (!run)
      begin
         next_st.overlap = 1'b0;
      end
      else
      begin
         if (pwmIn.minOffExpired)
         begin
            // overlap only when both phases exist and protections are live
            if (!pwmIn.aboveReg && dualPhase && overlapAllow)
               next_st.overlap = 1'b1;
            else if (pwmIn.aboveReg)
               next_st.overlap = 1'b0;
         end
         if (!overlapAllow)
            next_st.overlap = 1'b0;
         if (pwmIn.onRequest)
         begin
            if (next_st.overlap)
            begin
               next_st.mainPulse = 1'b1;
               next_st.secPulse = 1'b1;
            end
            else if (dualPhase)
            begin
               // lastSec untouched in overlap, so resume picks the opposite phase
               next_st.mainPulse = st.lastSec;
               next_st.secPulse = !st.lastSec;
               next_st.lastSec = !st.lastSec;
            end
            else
            begin
               next_st.mainPulse = 1'b1;
               next_st.lastSec = 1'b0;
            end
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rstSync_n)
   begin
      if (!rstSync_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign fireMain = st.mainPulse;
   assign fireSec = st.secPulse;
   assign overlapActive = st.overlap;
endmodule
`default_nettype wire

// ### verilog/vsm_sequencer.sv
// sequencing core: mode decode, dac slew, power-good, fault latch, gates
`default_nettype none
module vsm_sequencer
   import vsm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic activeLowEnable,
   input wire logic noFaultTest,
   input wire logic refUvloOk,
   input wire logic slewTick,
   input wire vsm_pkg::vsm_mode_in_t modeIn,
   input wire logic underVoltage,
   input wire logic overVoltage,
   input wire logic thermalFault,
   input wire logic pgoodUpperOk,
   input wire logic pgoodLowerOk,
   input wire vsm_pkg::vsm_pwm_in_t pwmIn,
   output logic refEnable,
   output logic [5:0] dacCode,
   output logic offsetEnable,
   output logic pulseSkip,
   output logic dualPhase,
   output vsm_pkg::vsm_gates_t gates,
   output logic powerGoodOut_n_oe,
   output logic faultLatched,
   output logic overlapActive
);
   // ****************************************************************
   // reset release and pin synchronisers
   // ****************************************************************
   logic [1:0] rstPipe;
   logic rstSync_n;

   // async assert, clocked release
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rstPipe <= 2'b00;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstSync_n = rstPipe[1];

   // every pin level except slewTick and pwmIn crosses in one two-stage bank
   localparam int SYN_W = 8 + $bits(vsm_mode_in_t);
   logic [SYN_W-1:0] syncA, syncB;
   always_ff @(posedge clk_sys or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         syncA <= '0;
         syncB <= '0;
      end
      else
      begin
         syncA <= {activeLowEnable, noFaultTest, refUvloOk, underVoltage, overVoltage,
                   thermalFault, pgoodUpperOk, pgoodLowerOk, modeIn};
         syncB <= syncA;
      end
   end

   // unpack the synchronised pins in packing order
   logic enSy, nfSy, refOkSy, uvSy, ovSy, thSy, pgUpSy, pgLoSy;
   vsm_mode_in_t modeSy;
   assign {enSy, nfSy, refOkSy, uvSy, ovSy, thSy, pgUpSy, pgLoSy, modeSy} = syncB;

   // ****************************************************************
   // mode decode and target selection
   // ****************************************************************
   // tri-level select at reference or high
   function automatic logic atRefOrHigh(input logic [1:0] lvl);
      atRefOrHigh = (lvl == SEL_REF) || (lvl == SEL_HIGH);
   endfunction

   // one lsb toward the target; equal codes hold
   function automatic logic [5:0] stepToward(input logic [5:0] cur, input logic [5:0] tgt);
      if (cur < tgt)
         stepToward = cur + 6'h01;
      else if (cur > tgt)
         stepToward = cur - 6'h01;
      else
         stepToward = cur;
   endfunction

   // target multiplexer
   logic suspendMode;
   logic [5:0] targetCode;
   assign suspendMode = atRefOrHigh(modeSy.susSel);
   // suspend code overrides everything
   assign targetCode = suspendMode ? modeSy.suspendCode : modeSy.vidCode;

   // ****************************************************************
   // state
   // ****************************************************************
   // whole core state in one packed register
   typedef struct packed {
      vsm_state_t phase;
      logic [5:0] dac;
      logic [1:0] quarterCnt;
      logic [1:0] fastCnt;
      logic fastActive;
      logic fault;
      logic enPrev;
      logic pgood;
      logic pgDelayRun;
      logic [31:0] pgDelayCnt;
      logic [4:0] blankCnt;
      logic blanking;
      logic [5:0] tgtPrev;
   } vsm_core_t;
   vsm_core_t s, next_s;

   // protections ignored in no-fault test mode
   logic anyFault;
   logic fastStep;
   assign anyFault = (uvSy || ovSy || thSy) && !nfSy;

   // fourfold rate: a pending tick spawns four steps on following cycles
   assign fastStep = s.fastActive;

   // sequencing, slew and power-good
   always_comb
   begin
      next_s = s;
      next_s.enPrev = enSy;
      next_s.tgtPrev = targetCode;
      if (nfSy)
         next_s.fault = 1'b0;
      if (!s.enPrev && enSy)
         next_s.fault = 1'b0;
      // protections stay live whenever the reference is up; set beats either clear
      if (anyFault && s.phase != ST_OFF && s.phase != ST_HALT)
      begin
         next_s.fault = 1'b1;
      end
      if (slewTick)
      begin
         next_s.fastActive = 1'b1;
         next_s.fastCnt = 2'(FAST_MULT - 1);
      end
      else if (s.fastActive)
      begin
         if (s.fastCnt == 2'h0)
            next_s.fastActive = 1'b0;
         else
            next_s.fastCnt = s.fastCnt - 2'h1;
      end
      unique case (s.phase)
         ST_OFF:
         begin
            next_s.dac = CODE_ZERO;
            next_s.pgood = 1'b0;
            if (enSy && !s.fault)
               next_s.phase = ST_REFUP;
         end
         ST_REFUP:
         begin
            if (!enSy)
               next_s.phase = ST_OFF;
            // a fault before switching parks the stage at zero code
            else if (anyFault)
               next_s.phase = ST_HALT;
            else if (refOkSy)
            begin
               next_s.phase = ST_RAMPUP;
               next_s.quarterCnt = '0;
            end
         end
         ST_RAMPUP, ST_RUN:
         begin
            if (!enSy || anyFault)
            begin
               next_s.phase = ST_RAMPDN;
               next_s.pgood = 1'b0;
               next_s.pgDelayRun = 1'b0;
               if (anyFault)
                  next_s.fault = 1'b1;
            end
            else if (s.phase == ST_RAMPUP)
            begin
               if (slewTick)
               begin
                  next_s.quarterCnt = s.quarterCnt + 2'h1;
                  if (s.quarterCnt == 2'(QUARTER_DIV - 1))
                     next_s.dac = stepToward(s.dac, targetCode);
               end
               if (s.dac == targetCode)
               begin
                  next_s.phase = ST_RUN;
                  next_s.pgDelayRun = 1'b1;
                  next_s.pgDelayCnt = '0;
               end
            end
            else
            begin
               // run: each tick steps toward whatever target is current now
               if (slewTick)
                  next_s.dac = stepToward(s.dac, targetCode);
               if (s.dac != targetCode || s.tgtPrev != targetCode)
               begin
                  next_s.blanking = 1'b1;
                  next_s.blankCnt = '0;
               end
               else if (s.blanking && slewTick)
               begin
                  if (s.blankCnt == 5'(BLANK_TICKS - 1))
                     next_s.blanking = 1'b0;
                  else
                     next_s.blankCnt = s.blankCnt + 5'h01;
               end
               if (s.pgDelayRun)
               begin
                  if (s.pgDelayCnt == 32'(PGOOD_DELAY_CYC - 1))
                     next_s.pgDelayRun = 1'b0;
                  else
                     next_s.pgDelayCnt = s.pgDelayCnt + 32'h0000_0001;
               end
               // upper check ignored while pulse skipping
               next_s.pgood = !next_s.pgDelayRun && !next_s.blanking && pgLoSy
                  && (pgUpSy || atRefOrHigh(modeSy.skipSel) == 1'b0 ||
                      modeSy.skipSel != SEL_HIGH);
            end
         end
         ST_RAMPDN:
         begin
            next_s.pgood = 1'b0;
            if (fastStep)
               next_s.dac = stepToward(s.dac, CODE_ZERO);
            if (s.dac == CODE_ZERO)
               next_s.phase = ST_HALT;
         end
         ST_HALT:
         begin
            next_s.pgood = 1'b0;
            // latch holds off restart until cleared by an enable toggle
            if (!enSy)
               next_s.phase = ST_OFF;
            else if (!s.fault && !s.enPrev)
               next_s.phase = ST_REFUP;
         end
         // unused state codes fall back to the parked state
         default:
         begin
            next_s.phase = ST_OFF;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         s <= '0;
         s.phase <= ST_OFF;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs and phase control
   // ****************************************************************
   // switching covers both ramps and regulation
   logic running;
   logic fireMain, fireSec;
   assign running = (s.phase == ST_RAMPUP) || (s.phase == ST_RUN) || (s.phase == ST_RAMPDN);

   // firing choice kept apart so the overlap logic stays small
   vsm_phase_ctl phaseCtl (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_n),
      .run(running),
      .dualPhase(dualPhase),
      .overlapAllow(!nfSy),
      .pwmIn(pwmIn),
      .fireMain(fireMain),
      .fireSec(fireSec),
      .overlapActive(overlapActive)
   );

   // mode decode straight from the synchronised selects
   assign dualPhase = atRefOrHigh(modeSy.skipSel);
   assign pulseSkip = (modeSy.skipSel != SEL_HIGH);
   assign offsetEnable = !suspendMode && modeSy.offsetValid && running;
   assign refEnable = (s.phase != ST_OFF) && (s.phase != ST_HALT);
   // registered status straight out
   assign dacCode = s.dac;
   assign faultLatched = s.fault;
   // open drain: enable high while power good pulls the pin low
   assign powerGoodOut_n_oe = s.pgood;
   // stopped: low-sides clamp the output, high-sides off
   assign gates.highSideMain = running && fireMain;
   assign gates.highSideSec = running && fireSec;
   assign gates.lowSideMain = !(running && fireMain);
   assign gates.lowSideSec = !(running && fireSec);
endmodule
`default_nettype wire

// ### verif/vsm_seq_sva.sv
// concurrent checks on the sequencing core ports
`default_nettype none
module vsm_seq_sva (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic noFaultTest,
   input wire logic slewTick,
   input wire logic overVoltage,
   input wire logic thermalFault,
   input wire logic refEnable,
   input wire logic [5:0] dacCode,
   input wire vsm_pkg::vsm_gates_t gates,
   input wire logic powerGoodOut_n_oe,
   input wire logic faultLatched,
   input wire logic overlapActive
);
   timeunit 1ns;
   timeprecision 100ps;
   import vsm_pkg::*;
   // *****
   // tick age and properties
   // *****
   logic [3:0] sinceTick;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // saturates so a long idle never wraps back into range
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sinceTick <= 4'hF;
      end
      else
      begin
         sinceTick <= slewTick ? 4'h0 : sinceTick + {3'h0, sinceTick != 4'hF};
      end
   end
   sequence hotFault;
      (overVoltage || thermalFault) && !noFaultTest && refEnable;
   endsequence
   AST_HS_EXCL: assert property (gates.highSideMain && gates.highSideSec
      |-> overlapActive || $past(overlapActive)) else $error("both high sides on");
   AST_SAFE_OFF: assert property (!refEnable
      |-> gates == 4'h3 && !powerGoodOut_n_oe) else $error("gates unsafe while off");
   AST_LSB_STEP: assert property ($changed(dacCode)
      |-> dacCode == $past(dacCode) + 6'h01 || dacCode == $past(dacCode) - 6'h01)
      else $error("dac moved more than one step");
   AST_TICK_PACED: assert property ($changed(dacCode) |-> sinceTick < 4'h8)
      else $error("dac moved with no recent tick");
   AST_PG_BLANK: assert property ($changed(dacCode) |-> ##[0:1] !powerGoodOut_n_oe)
      else $error("power good during slew");
   AST_FAULT_PG: assert property (faultLatched |-> ##[0:1] !powerGoodOut_n_oe)
      else $error("power good with fault");
   AST_FAULT_SET: assert property (hotFault [*6] |-> ##[0:4] faultLatched)
      else $error("fault not latched");
   AST_TEST_CLR: assert property (noFaultTest [*6] |=> !faultLatched && !overlapActive)
      else $error("test mode left latch or overlap");
endmodule
bind vsm_sequencer vsm_seq_sva i_vsm_seq_sva (.clk_sys(clk_sys), .nrst(nrst),
   .noFaultTest(noFaultTest), .slewTick(slewTick), .overVoltage(overVoltage),
   .thermalFault(thermalFault), .refEnable(refEnable), .dacCode(dacCode), .gates(gates),
   .powerGoodOut_n_oe(powerGoodOut_n_oe), .faultLatched(faultLatched),
   .overlapActive(overlapActive));
`default_nettype wire

// ### verif/vsm_far_end.sv
// far side model: processor vid driver and two-phase power stage
`default_nettype none
module vsm_far_end (
   input wire logic clk_sys,
   input wire logic heavyLoad,
   input wire logic [5:0] vidReq,
   input wire vsm_pkg::vsm_gates_t gates,
   output vsm_pkg::vsm_pwm_in_t pwmIn = '0,
   output logic [5:0] vidCode = 6'h00
);
   timeunit 1ns;
   timeprecision 100ps;
   import vsm_pkg::*;
   // *****
   // stage model
   // *****
   logic [3:0] period = 4'h0;
   logic [1:0] offAge = 2'h0;
   logic hsWas = 1'b0;
   // one-shot rearms every 16 cycles; min off-time ends 4 cycles after a high side drops
   always @(posedge clk_sys)
   begin
      period <= period + 4'h1;
      hsWas <= gates.highSideMain | gates.highSideSec;
      if (hsWas && !(gates.highSideMain | gates.highSideSec))
      begin
         offAge <= 2'h3;
      end
      else if (offAge != 2'h0)
      begin
         offAge <= offAge - 2'h1;
      end
      pwmIn.onRequest <= period == 4'hF;
      pwmIn.minOffExpired <= offAge == 2'h1;
      pwmIn.aboveReg <= !heavyLoad; // a load step holds the output low
      vidCode <= vidReq;
   end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the vid slew mode sequencer
`default_nettype none
`define CHK(g, e) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
      end \
   end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import vsm_pkg::*;
   logic clk_sys = 1'b0, nrst = 1'b0, en = 1'b0, nft = 1'b0, uvlo = 1'b0, tick = 1'b0;
   logic uv = 1'b0, ov = 1'b0, th = 1'b0, heavy = 1'b0, ofsOk = 1'b0;
   logic [1:0] sus = SEL_GND, skip = SEL_HIGH;
   logic [5:0] vidReq = 6'h05, vid, dac;
   vsm_gates_t gates;
   vsm_pwm_in_t pwmIn;
   logic refEn, ofsEn, pSkip, dual, pgOe, fault, ovl;
   logic lastSec = 1'b0, prevSec = 1'b0, firstSec = 1'b0, ovlWas = 1'b0, pend = 1'b0;
   int errors = 0, n_compared = 0, cyc = 0, nMain = 0, nSec = 0, nBoth = 0;
   vsm_sequencer i_vsm_sequencer (.clk_sys(clk_sys), .nrst(nrst), .activeLowEnable(en),
      .noFaultTest(nft), .refUvloOk(uvlo), .slewTick(tick),
      .modeIn({sus, skip, ofsOk, vid, 6'h04}), .underVoltage(uv), .overVoltage(ov),
      .thermalFault(th), .pgoodUpperOk(1'b1), .pgoodLowerOk(1'b1), .pwmIn(pwmIn),
      .refEnable(refEn), .dacCode(dac), .offsetEnable(ofsEn), .pulseSkip(pSkip),
      .dualPhase(dual), .gates(gates), .powerGoodOut_n_oe(pgOe), .faultLatched(fault),
      .overlapActive(ovl));
   vsm_far_end i_vsm_far_end (.clk_sys(clk_sys), .heavyLoad(heavy), .vidReq(vidReq),
      .gates(gates), .pwmIn(pwmIn), .vidCode(vid));
   // *****
   // clock, watchdog, firing monitor
   // *****
   always #2.5 clk_sys = ~clk_sys;
   // a hang counts as a mismatch
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc > 12000)
      begin
         errors++;
         wrap_up();
      end
   end
   // sampled mid-cycle so one-cycle gate pulses are settled
   always @(negedge clk_sys)
   begin
      if (ovl && !ovlWas)
      begin
         prevSec = lastSec;
         pend = 1'b1;
      end
      ovlWas = ovl;
      if (gates.highSideMain && gates.highSideSec)
      begin
         nBoth++;
      end
      else if (gates.highSideMain || gates.highSideSec)
      begin
         nMain += gates.highSideMain;
         nSec += gates.highSideSec;
         lastSec = gates.highSideSec;
         if (pend && !ovl)
         begin
            firstSec = gates.highSideSec;
            pend = 1'b0;
         end
      end
   end
   // *****
   // tasks
   // *****
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // ticks ten cycles apart, room for four shutdown steps each
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(negedge clk_sys) tick = 1'b1;
         @(negedge clk_sys) tick = 1'b0;
         wait_n(8);
      end
   endtask
   task automatic done(input string s);
      $display("end of test %s", s);
   endtask
   task automatic power_up(input int t);
      en = 1'b1;
      wait_n(6);
      `CHK(refEn, 1'b1);
      ticks(4);
      `CHK(dac, 6'h00);
      uvlo = 1'b1;
      wait_n(6);
      ticks(3);
      `CHK(dac, 6'h00);
      ticks(4 * t - 3);
      `CHK(dac, 6'(t));
      `CHK(pgOe, 1'b0);
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // *****
   // test sequence
   // *****
   initial
   begin
      wait_n(12);
      nrst = 1'b1;
      wait_n(6);
      `CHK(dac, 6'h00);
      `CHK(gates, 4'h3);
      `CHK(refEn, 1'b0);
      power_up(5);
      done("power up");
      vidReq = 6'h08;
      wait_n(6);
      ticks(1);
      `CHK(dac, 6'h06);
      vidReq = 6'h02;
      wait_n(6);
      ticks(1);
      `CHK(dac, 6'h05);
      ticks(3);
      `CHK(dac, 6'h02);
      done("vid slew");
      for (int i = 0; i < 3; i++)
      begin
         skip = 2'(i);
         wait_n(6);
         `CHK(pSkip, 1'(i != 2));
         `CHK(dual, 1'(i != 0));
      end
      ofsOk = 1'b1;
      wait_n(6);
      `CHK(ofsEn, 1'b1);
      sus = SEL_REF;
      wait_n(6);
      `CHK(ofsEn, 1'b0);
      ticks(2);
      sus = SEL_HIGH;
      ticks(1);
      `CHK(dac, 6'h04);
      sus = SEL_GND;
      ofsOk = 1'b0;
      wait_n(6);
      `CHK(ofsEn, 1'b0);
      ticks(2);
      `CHK(dac, 6'h02);
      done("modes");
      // count only the dual-phase stretch; the single-phase window skews the tally
      nMain = 0;
      nSec = 0;
      wait_n(100);
      `CHK(nBoth, 0);
      `CHK(1'(nMain - nSec inside {-1, 0, 1} && nSec > 2), 1'b1);
      heavy = 1'b1;
      wait_n(100);
      `CHK(ovl, 1'b1);
      `CHK(1'(nBoth > 2), 1'b1);
      heavy = 1'b0;
      wait_n(60);
      `CHK(ovl, 1'b0);
      `CHK(pend, 1'b0);
      `CHK(firstSec, !prevSec);
      nft = 1'b1;
      heavy = 1'b1;
      wait_n(60);
      `CHK(ovl, 1'b0);
      nft = 1'b0;
      heavy = 1'b0;
      done("phases");
      vidReq = 6'h09;
      wait_n(6);
      ticks(7);
      en = 1'b0;
      wait_n(6);
      `CHK(pgOe, 1'b0);
      ticks(1);
      `CHK(dac, 6'h05);
      ticks(2);
      `CHK(dac, 6'h00);
      `CHK(refEn, 1'b0);
      uvlo = 1'b0;
      done("shutdown");
      for (int k = 0; k < 3; k++)
      begin
         power_up(9);
         `CHK(fault, 1'b0);
         ticks(25);
         {uv, ov, th} = 3'h4 >> k;
         wait_n(6);
         ticks(3);
         `CHK(fault, 1'b1);
         `CHK(dac, 6'h00);
         `CHK(gates, 4'h3);
         {uv, ov, th} = 3'h0;
         uvlo = 1'b0;
         ticks(8);
         `CHK(refEn, 1'b0);
         nft = (k == 2);
         wait_n(8);
         `CHK(fault, 1'(k != 2));
         nft = 1'b0;
         en = 1'b0;
         wait_n(6);
      end
      done("faults");
      wrap_up();
   end
endmodule
`default_nettype wire
